// ---- hw/ssfi_top.sv ----
// Status lamps, relays, fault memory and observer command handling of a servo controller.
// Assumes commands arrive already decoded as one-cycle packets synchronous to clk.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Flash the red fault lamp while the controller boots.
// - Switch the red lamp off after boot with a valid configuration.
// - Keep flashing after boot until configured over serial if never configured.
// - Fault while enabled: green lamp off, red lamp steady on.
// - New enable clears the records of faults not present at that moment, and switches red lamp off if none is present.
// - Thermal torque limit lights yellow lamp and opens thermal relay.
// - Light green lamp as soon as the drive is enabled.
// - Green lamp off when disabled or when a fault lights red lamp.
// - Close ready relay when operating without fault.
// - Open ready relay on fault or switch-off; open when unpowered.
// - Fault-query command reports the fault memory.
// - Cleared faults report occurred-but-gone, kept until next enable.
// - Active faults report a distinct still-present status.
// - Jog mode accepts up, down, set, zero, list and quit keys.
// - Each up or down key changes inertia by five percent.
// - After initialization inertia estimate is twice motor inertia.
// - Observer activation switches estimated speed into speed feedback.
// - Output-select code five routes observer position error to test output.
// - Bandwidth command accepts up to about 600 Hz with observer active.
module ssfi_top
    import ssfi_pkg::*;
#(
    parameter int unsigned FLASH_CYCLES = FLASH_HALF_CYC,
    parameter int unsigned FAULTS       = NUM_FAULTS
) (
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Controller state.
    input  wire logic                 bootDone,
    input  wire logic                 configValid,
    input  wire logic                 driveEnable,
    input  wire logic                 powerOn,
    input  wire logic                 thermalLimit,
    input  wire logic [FAULTS-1:0]    faultActive,
    input  wire logic [INERTIA_W-1:0] motorInertia,
    // Decoded serial command.
    input  wire ssfi_cmd_pkt_t        cmd,
    // Indicators and relays.
    output var  ssfi_lamps_t          lamps,
    // Serial replies.
    output var  ssfi_fault_rpt_t      faultReport,
    output var  ssfi_list_rpt_t       listReport,
    // Observer and test output control.
    output logic [INERTIA_W-1:0]      inertiaEst,
    output logic                      observerFeedback,
    output logic [2:0]                testOutSel,
    output logic [BW_W-1:0]           bandwidth,
    output logic                      jogActive
);

    // Refuse fault counts that the readout cannot hold and prescalers too short to show a flash.
    if (FAULTS < 1 || FAULTS > NUM_FAULTS || FLASH_CYCLES < 2) begin : g_badParams
        $error("ssfi_top: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode.

    // A packet counts only in the cycle in which it is marked valid.
    function automatic logic cmd_is(
        input ssfi_cmd_pkt_t pkt,
        input ssfi_cmd_t     kind
    );
        return pkt.valid && pkt.code == kind;
    endfunction : cmd_is

    logic doConfigure;
    logic doFaultQuery;
    logic doJogEnter;
    logic doKeyQuit;
    logic doKeyList;
    logic doInertiaSet;
    logic doObsOn;
    logic doOutSel;
    logic doBwSet;
    logic jogKey;

    assign doConfigure  = cmd_is(cmd, CMD_CONFIGURE);
    assign doFaultQuery = cmd_is(cmd, CMD_FAULT_QUERY);
    assign doJogEnter   = cmd_is(cmd, CMD_JOG_ENTER);
    assign doKeyQuit    = cmd_is(cmd, CMD_KEY_QUIT);
    assign doKeyList    = cmd_is(cmd, CMD_KEY_LIST) && jogActive;
    assign doInertiaSet = cmd_is(cmd, CMD_INERTIA_SET);
    assign doObsOn      = cmd_is(cmd, CMD_OBS_ON);
    assign doOutSel     = cmd_is(cmd, CMD_OUT_SEL);
    assign doBwSet      = cmd_is(cmd, CMD_BW_SET);
    // Single keys are honoured only inside jog-key mode.
    assign jogKey       = cmd.valid && jogActive;

    ////////////////////////////////////////////////////////////////////////////////
    // Flash prescaler.

    localparam int unsigned FW = $clog2(FLASH_CYCLES);

    logic [FW-1:0] flashCnt_q;
    logic          flashPhase_q;

    // The phase toggles every FLASH_CYCLES cycles, giving equal on and off times.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flashCnt_q   <= '0;
            flashPhase_q <= 1'b0;
        end else if (flashCnt_q == FW'(FLASH_CYCLES - 1)) begin
            flashCnt_q   <= '0;
            flashPhase_q <= ~flashPhase_q;
        end else begin
            flashCnt_q <= flashCnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration memory and fault records.

    logic              configured_q;
    logic              enable_q;
    logic [FAULTS-1:0] faultSeen_q;
    logic              faultLatched_q;
    logic              enableRise;
    logic              anyFault;

    assign enableRise = driveEnable & ~enable_q;
    assign anyFault   = |faultActive;

    // A configuration found at boot or sent over the serial link ends the boot flash.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            configured_q <= 1'b0;
        end else if (bootDone && configValid) begin
            configured_q <= 1'b1;
        end else if (doConfigure) begin
            configured_q <= 1'b1;
        end
    end

    // The registered enable finds the rising edge that starts a new enable.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_q <= 1'b0;
        end else begin
            enable_q <= driveEnable;
        end
    end

    // A fault arriving in the enable cycle is recorded: the set wins over the clear.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            faultSeen_q <= '0;
        end else if (enableRise) begin
            faultSeen_q <= faultActive;
        end else begin
            faultSeen_q <= faultSeen_q | faultActive;
        end
    end

    // The latch holds the red lamp steady after the cause goes away, until the next enable.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            faultLatched_q <= 1'b0;
        end else if (enableRise) begin
            faultLatched_q <= anyFault;
        end else if (anyFault && (driveEnable || enable_q)) begin
            faultLatched_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Lamps and relays.

    logic booting;
    logic faultShown;

    // A cause still present shows the fault before the latch has caught it.
    assign booting    = !bootDone || !configured_q;
    assign faultShown = faultLatched_q || anyFault;

    // A fault outranks the boot flash, so a fault during boot is shown steadily.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lamps <= '0;
        end else begin
            if (faultShown) begin
                lamps.faultLamp <= 1'b1;
            end else if (booting) begin
                lamps.faultLamp <= flashPhase_q;
            end else begin
                lamps.faultLamp <= 1'b0;
            end
            lamps.thermalLimitLamp   <= thermalLimit;
            lamps.thermalRelayClosed <= powerOn && !thermalLimit;
            lamps.enableLamp         <= driveEnable && !faultShown;
            lamps.readyRelayClosed   <= powerOn && !booting && !anyFault;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Fault memory readout.

    // Present outranks occurred, so a cause that returns is reported as present again.
    function automatic logic [2*NUM_FAULTS-1:0] fault_status(
        input logic [FAULTS-1:0] seen,
        input logic [FAULTS-1:0] active
    );
        logic [2*NUM_FAULTS-1:0] r;
        r = '0;
        for (int i = 0; i < FAULTS; i++) begin
            if (active[i]) begin
                r[2*i +: 2] = FAULT_PRESENT;
            end else if (seen[i]) begin
                r[2*i +: 2] = FAULT_OCCURRED;
            end else begin
                r[2*i +: 2] = FAULT_NONE;
            end
        end
        return r;
    endfunction : fault_status

    // The report shows the records and the live causes as they stand when the query is taken.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            faultReport <= '0;
        end else begin
            faultReport.valid  <= doFaultQuery;
            faultReport.status <= fault_status(faultSeen_q, faultActive);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Inertia estimate and jog-key mode.

    logic                 initDone_q;
    logic [INERTIA_W-1:0] step;

    // The five percent step truncates and follows the current estimate, so an up key followed by a down key drifts slightly down.
    assign step = inertiaEst / INERTIA_W'(STEP_DIV);

    // Quit leaves jog-key mode; the key is harmless outside it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            jogActive <= 1'b0;
        end else if (doJogEnter) begin
            jogActive <= 1'b1;
        end else if (doKeyQuit) begin
            jogActive <= 1'b0;
        end
    end

    // The estimate is seeded once, when boot first completes; commands overwrite it later.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            initDone_q <= 1'b0;
            inertiaEst <= '0;
        end else if (!initDone_q && bootDone) begin
            initDone_q <= 1'b1;
            inertiaEst <= INERTIA_W'(motorInertia * INERTIA_MUL);
        end else if (doInertiaSet) begin
            inertiaEst <= cmd.arg;
        end else if (jogKey) begin
            case (cmd.code)
                CMD_KEY_UP: begin
                    inertiaEst <= inertiaEst + step;
                end
                CMD_KEY_DOWN: begin
                    inertiaEst <= inertiaEst - step;
                end
                CMD_KEY_SET: begin
                    inertiaEst <= cmd.arg;
                end
                CMD_KEY_ZERO: begin
                    inertiaEst <= '0;
                end
                default: begin
                    inertiaEst <= inertiaEst;
                end
            endcase
        end
    end

    // The list reply carries the estimate as it stands when the key is taken.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            listReport <= '0;
        end else begin
            listReport.valid   <= doKeyList;
            listReport.inertia <= inertiaEst;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Observer activation, test output and bandwidth.

    // Once switched into the feedback path the observer stays there until reset.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            observerFeedback <= 1'b0;
        end else if (doObsOn) begin
            observerFeedback <= 1'b1;
        end
    end

    // Codes outside the table leave the selection as it was.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            testOutSel <= TEST_SEL_RESET;
        end else if (doOutSel) begin
            case (cmd.arg[2:0])
                TEST_OUT_ACTUAL_SPEED, 3'h2, 3'h3, TEST_OUT_OBSERVER_SPEED,
                TEST_OUT_OBSERVER_ERROR: begin
                    testOutSel <= cmd.arg[2:0];
                end
                default: begin
                    testOutSel <= testOutSel;
                end
            endcase
        end
    end

    // A setting above the limit, upper argument bits included, is dropped without indication.
    logic [INERTIA_W-1:0] bwLimit;

    assign bwLimit = INERTIA_W'(observerFeedback ? BW_MAX_HZ : BW_MAX_NO_OBS);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bandwidth <= BW_RESET;
        end else if (doBwSet) begin
            if (cmd.arg <= bwLimit) begin
                bandwidth <= cmd.arg[BW_W-1:0];
            end
        end
    end

endmodule : ssfi_top

`default_nettype wire

// ---- include/ssfi_pkg.sv ----
// Constants, command codes and carrier types for the servo status and fault indicator.
// Assumes a single 10 MHz system clock and an active-high asynchronous reset.
package ssfi_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and timing.
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned FLASH_HALF_MS   = 250;
    localparam int unsigned FLASH_HALF_CYC  = CLK_HZ / 1000 * FLASH_HALF_MS;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths and reset values.
    localparam int unsigned NUM_FAULTS      = 5;
    localparam int unsigned INERTIA_W       = 24;
    localparam int unsigned BW_W            = 12;
    localparam logic [11:0] BW_MAX_HZ       = 12'h258;
    localparam logic [11:0] BW_MAX_NO_OBS   = 12'h0c8;
    localparam logic [11:0] BW_RESET        = 12'h064;
    localparam logic [2:0]  TEST_SEL_RESET  = 3'h1;
    localparam int unsigned INERTIA_MUL     = 2;
    localparam int unsigned STEP_DIV        = 20;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial command codes, already decoded by the terminal front end.
    typedef enum logic [3:0] {
        CMD_NONE        = 4'h0,
        CMD_FAULT_QUERY = 4'h1,
        CMD_JOG_ENTER   = 4'h2,
        CMD_KEY_UP      = 4'h3,
        CMD_KEY_DOWN    = 4'h4,
        CMD_KEY_SET     = 4'h5,
        CMD_KEY_ZERO    = 4'h6,
        CMD_KEY_LIST    = 4'h7,
        CMD_KEY_QUIT    = 4'h8,
        CMD_INERTIA_SET = 4'h9,
        CMD_OBS_ON      = 4'ha,
        CMD_OUT_SEL     = 4'hb,
        CMD_BW_SET      = 4'hc,
        CMD_CONFIGURE   = 4'hd
    } ssfi_cmd_t;

    // Test output codes.
    localparam logic [2:0] TEST_OUT_ACTUAL_SPEED   = 3'h1;
    localparam logic [2:0] TEST_OUT_OBSERVER_SPEED = 3'h4;
    localparam logic [2:0] TEST_OUT_OBSERVER_ERROR = 3'h5;

    // Fault record status codes.
    localparam logic [1:0] FAULT_NONE     = 2'h0;
    localparam logic [1:0] FAULT_OCCURRED = 2'h1;
    localparam logic [1:0] FAULT_PRESENT  = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // Carriers.
    typedef struct packed {
        logic                 valid;
        ssfi_cmd_t            code;
        logic [INERTIA_W-1:0] arg;
    } ssfi_cmd_pkt_t;

    typedef struct packed {
        logic faultLamp;
        logic thermalLimitLamp;
        logic enableLamp;
        logic readyRelayClosed;
        logic thermalRelayClosed;
    } ssfi_lamps_t;

    typedef struct packed {
        logic                    valid;
        logic [2*NUM_FAULTS-1:0] status;
    } ssfi_fault_rpt_t;

    typedef struct packed {
        logic                 valid;
        logic [INERTIA_W-1:0] inertia;
    } ssfi_list_rpt_t;

endpackage : ssfi_pkg

// ---- bench/ssfi_term.sv ----
// Commissioning terminal model: turns operator requests into decoded command packets.
// Assumes the bench raises go for one cycle per command.
`timescale 1ns/100ps
`default_nettype none
module ssfi_term
    import ssfi_pkg::*;
(
    // Clock and reset.
    input  wire logic          clk,
    input  wire logic          rst,
    // Operator request.
    input  wire logic          go,
    input  wire ssfi_cmd_t     code,
    input  wire logic [23:0]   arg,
    // Decoded command.
    output var  ssfi_cmd_pkt_t cmd
);
    // Between commands the code and argument fields invert every cycle, alternating between the last values and their inverse.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd <= '0;
        end else if (go) begin
            cmd <= '{valid: 1'b1, code: code, arg: arg};
        end else begin
            cmd <= '{valid: 1'b0, code: ssfi_cmd_t'(~cmd.code), arg: ~cmd.arg};
        end
    end
endmodule : ssfi_term
`default_nettype wire

// ---- bench/ssfi_top_checker.sv ----
// Port-level checker for the status and fault indicator.
// Assumes it is bound into ssfi_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module ssfi_top_checker
    import ssfi_pkg::*;
#(
    parameter int unsigned FAULTS = NUM_FAULTS
) (
    // Clock and reset.
    input wire logic                 clk,
    input wire logic                 rst,
    // Inputs watched.
    input wire logic                 bootDone,
    input wire logic                 configValid,
    input wire logic                 driveEnable,
    input wire logic                 powerOn,
    input wire logic                 thermalLimit,
    input wire logic [FAULTS-1:0]    faultActive,
    input wire ssfi_cmd_pkt_t        cmd,
    // Outputs watched.
    input wire ssfi_lamps_t          lamps,
    input wire ssfi_fault_rpt_t      faultReport,
    input wire logic [INERTIA_W-1:0] inertiaEst,
    input wire logic                 jogActive,
    input wire logic                 observerFeedback,
    input wire logic [2:0]           testOutSel
);
    logic isQuery;
    assign isQuery = cmd.valid && cmd.code == CMD_FAULT_QUERY;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    property p_thermal;
        thermalLimit |=> lamps.thermalLimitLamp && !lamps.thermalRelayClosed;
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal lamp or relay wrong");
    property p_ready_open;
        (!powerOn || faultActive != '0) |=> !lamps.readyRelayClosed;
    endproperty
    a_ready_open: assert property (p_ready_open) else $error("ready relay not open");
    property p_ready_close;
        (powerOn && bootDone && configValid && $past(bootDone && configValid) && faultActive == '0)
            |=> lamps.readyRelayClosed;
    endproperty
    a_ready_close: assert property (p_ready_close) else $error("ready relay not closed");
    property p_enable_off;
        !driveEnable |=> !lamps.enableLamp;
    endproperty
    a_enable_off: assert property (p_enable_off) else $error("enable lamp lit while disabled");
    property p_fault_on;
        (driveEnable && faultActive != '0) |=> lamps.faultLamp && !lamps.enableLamp;
    endproperty
    a_fault_on: assert property (p_fault_on) else $error("fault lamps wrong");
    property p_query;
        isQuery |=> faultReport.valid;
    endproperty
    a_query: assert property (p_query) else $error("no fault report");
    property p_rpt_cause;
        faultReport.valid |-> $past(isQuery);
    endproperty
    a_rpt_cause: assert property (p_rpt_cause) else $error("fault report without query");
    property p_present;
        (isQuery && faultActive[0]) |=> faultReport.status[1:0] == FAULT_PRESENT;
    endproperty
    a_present: assert property (p_present) else $error("active fault not present");
    property p_jog_ignored;
        (cmd.valid && cmd.code == CMD_KEY_UP && !jogActive && bootDone && $past(bootDone)) |=> $stable(inertiaEst);
    endproperty
    a_jog_ignored: assert property (p_jog_ignored) else $error("key taken outside jog");
    property p_observer;
        (cmd.valid && cmd.code == CMD_OBS_ON) |=> observerFeedback;
    endproperty
    a_observer: assert property (p_observer) else $error("observer not in feedback");
    property p_sel5;
        (cmd.valid && cmd.code == CMD_OUT_SEL && cmd.arg == 24'h000005) |=> testOutSel == TEST_OUT_OBSERVER_ERROR;
    endproperty
    a_sel5: assert property (p_sel5) else $error("test output not observer error");
endmodule : ssfi_top_checker
bind ssfi_top ssfi_top_checker #(.FAULTS(FAULTS)) uChecker (.clk(clk), .rst(rst), .bootDone(bootDone),
    .configValid(configValid), .driveEnable(driveEnable), .powerOn(powerOn), .thermalLimit(thermalLimit),
    .faultActive(faultActive), .cmd(cmd), .lamps(lamps), .faultReport(faultReport), .inertiaEst(inertiaEst),
    .jogActive(jogActive), .observerFeedback(observerFeedback), .testOutSel(testOutSel));
`default_nettype wire

// ---- bench/tb_ssfi_top.sv ----
// Self-checking bench for the status and fault indicator.
// Assumes ssfi_term as command source and a short flash prescaler.
`timescale 1ns/100ps
`default_nettype none
module tb_ssfi_top;
    import ssfi_pkg::*;
    localparam logic [23:0] MOTOR_J = 24'h000c80;
    logic            clk = 1'b0, rst = 1'b1, go = 1'b0;
    logic            bootDone = 1'b0, configValid = 1'b0, driveEnable = 1'b0, powerOn = 1'b1, thermalLimit = 1'b0;
    logic [4:0]      faultActive = 5'h00;
    ssfi_cmd_t       code = CMD_NONE;
    logic [23:0]     arg = 24'h000000, inertiaEst, expJ;
    ssfi_cmd_pkt_t   cmd;
    ssfi_lamps_t     lamps;
    ssfi_fault_rpt_t faultReport;
    ssfi_list_rpt_t  listReport;
    logic            observerFeedback, jogActive;
    logic [2:0]      testOutSel;
    logic [11:0]     bandwidth;
    int              failCount = 0, numChecks = 0, cycles = 0;
    always #50 clk = ~clk;
    ssfi_term uTerm (.clk(clk), .rst(rst), .go(go), .code(code), .arg(arg), .cmd(cmd));
    ssfi_top #(.FLASH_CYCLES(4)) DUT (.clk(clk), .rst(rst), .bootDone(bootDone), .configValid(configValid),
        .driveEnable(driveEnable), .powerOn(powerOn), .thermalLimit(thermalLimit), .faultActive(faultActive),
        .motorInertia(MOTOR_J), .cmd(cmd), .lamps(lamps), .faultReport(faultReport), .listReport(listReport),
        .inertiaEst(inertiaEst), .observerFeedback(observerFeedback), .testOutSel(testOutSel),
        .bandwidth(bandwidth), .jogActive(jogActive));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic giveVerdict;
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : giveVerdict
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic send(input ssfi_cmd_t c, input logic [23:0] a);
        @(posedge clk);
        go <= 1'b1;
        code <= c;
        arg <= a;
        @(posedge clk);
        go <= 1'b0;
        settle(1);
    endtask : send
    // Over 16 cycles a lamp flashing 4 on, 4 off is lit exactly 8 times.
    task automatic flash(input string name);
        int ones;
        ones = 0;
        repeat (16) begin
            settle(1);
            ones += lamps.faultLamp;
        end
        chk(name, 24'(ones), 24'd8);
    endtask : flash
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_boot;
        chk("bandwidth", bandwidth, BW_RESET);
        chk("testOutSel", testOutSel, TEST_SEL_RESET);
        flash("bootFlash");
        @(posedge clk);
        bootDone <= 1'b1;
        settle(2);
        chk("initInertia", inertiaEst, MOTOR_J * 2);
        flash("unconfFlash");
        send(CMD_CONFIGURE, 24'h000000);
        settle(1);
        chk("lampOff", lamps.faultLamp, 1'b0);
        chk("readyClosed", lamps.readyRelayClosed, 1'b1);
        $display("t_boot done");
    endtask : t_boot
    task automatic t_fault;
        @(posedge clk);
        configValid <= 1'b1;
        driveEnable <= 1'b1;
        settle(2);
        chk("enableOn", lamps.enableLamp, 1'b1);
        @(posedge clk);
        faultActive <= 5'h01;
        settle(2);
        chk("faultLamps", {lamps.faultLamp, lamps.enableLamp, lamps.readyRelayClosed}, 3'b100);
        send(CMD_FAULT_QUERY, 24'h000000);
        chk("present", faultReport, {1'b1, 8'h00, FAULT_PRESENT});
        @(posedge clk);
        faultActive <= 5'h00;
        settle(2);
        send(CMD_FAULT_QUERY, 24'h000000);
        chk("occurred", faultReport, {1'b1, 8'h00, FAULT_OCCURRED});
        chk("latched", lamps.faultLamp, 1'b1);
        @(posedge clk);
        driveEnable <= 1'b0;
        settle(2);
        @(posedge clk);
        driveEnable <= 1'b1;
        settle(2);
        send(CMD_FAULT_QUERY, 24'h000000);
        chk("cleared", faultReport, {1'b1, 10'h000});
        chk("clearedLamps", {lamps.faultLamp, lamps.enableLamp}, 2'b01);
        @(posedge clk);
        powerOn <= 1'b0;
        thermalLimit <= 1'b1;
        settle(2);
        chk("offReady", lamps.readyRelayClosed, 1'b0);
        chk("thermal", {lamps.thermalLimitLamp, lamps.thermalRelayClosed}, 2'b10);
        @(posedge clk);
        powerOn <= 1'b1;
        thermalLimit <= 1'b0;
        $display("t_fault done");
    endtask : t_fault
    task automatic t_jog;
        expJ = MOTOR_J * 2;
        send(CMD_KEY_UP, 24'h000000);
        chk("upIgnored", inertiaEst, expJ);
        send(CMD_JOG_ENTER, 24'h000000);
        chk("jogOn", jogActive, 1'b1);
        send(CMD_KEY_UP, 24'h000000);
        expJ = expJ + expJ / 20;
        chk("up", inertiaEst, expJ);
        send(CMD_KEY_DOWN, 24'h000000);
        expJ = expJ - expJ / 20;
        chk("down", inertiaEst, expJ);
        send(CMD_KEY_LIST, 24'h000000);
        chk("list", listReport, {1'b1, expJ});
        send(CMD_KEY_SET, 24'h001234);
        chk("set", inertiaEst, 24'h001234);
        send(CMD_KEY_ZERO, 24'h000000);
        chk("zero", inertiaEst, 24'h000000);
        send(CMD_KEY_QUIT, 24'h000000);
        chk("quit", jogActive, 1'b0);
        send(CMD_KEY_LIST, 24'h000000);
        chk("listIgnored", listReport.valid, 1'b0);
        send(CMD_INERTIA_SET, 24'h000abc);
        chk("directSet", inertiaEst, 24'h000abc);
        $display("t_jog done");
    endtask : t_jog
    task automatic t_obs;
        send(CMD_BW_SET, 24'h0001f4);
        chk("bwRefused", bandwidth, BW_RESET);
        send(CMD_OBS_ON, 24'h000000);
        chk("observer", observerFeedback, 1'b1);
        send(CMD_BW_SET, 24'h000258);
        chk("bwMax", bandwidth, 12'h258);
        send(CMD_BW_SET, 24'h000259);
        chk("bwOver", bandwidth, 12'h258);
        send(CMD_BW_SET, 24'h001064);
        chk("bwWide", bandwidth, 12'h258);
        send(CMD_OUT_SEL, 24'h000005);
        chk("sel5", testOutSel, TEST_OUT_OBSERVER_ERROR);
        send(CMD_OUT_SEL, 24'h000006);
        chk("sel6", testOutSel, TEST_OUT_OBSERVER_ERROR);
        send(CMD_OUT_SEL, 24'h000004);
        chk("sel4", testOutSel, TEST_OUT_OBSERVER_SPEED);
        send(CMD_OUT_SEL, 24'h000001);
        chk("sel1", testOutSel, TEST_OUT_ACTUAL_SPEED);
        $display("t_obs done");
    endtask : t_obs
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            failCount++;
            giveVerdict();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        t_boot();
        t_fault();
        t_jog();
        t_obs();
        giveVerdict();
    end
endmodule : tb_ssfi_top
`default_nettype wire
